// [inc/fsw_pkg.sv]
/*
 * Constants and carrier types for the fail-safe watchdog.
 * Assumes a single 250 MHz system clock standing in for the CPU clock.
 */
// Summary of operation
// - After any reset the watchdog is enabled and counting with no software action.
// - The disable instruction works only before end-of-initialization, then not until reset.
// - On overflow the block raises an internal reset and drives the reset output pin low.
// - The counter is a 16-bit up-counter clocked by the CPU clock divided by 2 or 128.
// - A software-written reload value feeds the counter's upper eight bits.
// - Each service instruction outside an internal reset loads the reload value into the counter's upper byte.
// - With reset defaults the overflow comes after the full 16-bit count at divide-by-2.
// - Prescaler choice and reload value span intervals from about 25 us to 420 ms at 20 MHz.
// - End-of-initialization releases the reset output pin and closes the disable window.
package fsw_pkg;

    ////////////////////////////////////////////////////////////////////////
    localparam int CNT_W = 16;
    localparam int PRE_W = 7;
    localparam logic [PRE_W-1:0] PRE_DIV2_LAST = 7'h01;
    localparam logic [PRE_W-1:0] PRE_DIV128_LAST = 7'h7f;
    localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
    localparam logic [7:0] RELOAD_RESET = 8'h00;
    localparam logic PRESEL_RESET = 1'b0;
    // Internal reset pulse length in cycles
    localparam int RST_PULSE_CYC = 8;
    localparam logic [3:0] RST_PULSE_LAST = 4'(RST_PULSE_CYC - 1);

    ////////////////////////////////////////////////////////////////////////
    // CPU instruction strobes, one-cycle pulses
    typedef struct packed {
        logic service_watchdog_instr;
        logic disable_watchdog_instr;
        logic end_of_init_instr;
    } fsw_instr_t;

    // Software-written configuration
    typedef struct packed {
        logic wr;
        logic presel_div128;
        logic [7:0] watchdog_reload_value;
    } fsw_cfg_t;

    typedef enum logic [2:0] {
        ST_INIT = 3'h1,
        ST_RUN = 3'h2,
        ST_RESET = 3'h4
    } fsw_state_t;

endpackage : fsw_pkg

// [rtl/fsw_prescaler.sv]
/*
 * Prescaler for the watchdog: divide-by-2 or divide-by-128 tick.
 * Assumes the tick is consumed on the same clock.
 */
`timescale 1ns/1ps
module fsw_prescaler (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Control
    input wire logic clear_i,
    input wire logic div128_i,
    // Tick
    output logic tick_o
);

    logic [fsw_pkg::PRE_W-1:0] pre_r;
    wire [fsw_pkg::PRE_W-1:0] last_w = div128_i ? fsw_pkg::PRE_DIV128_LAST
                                                : fsw_pkg::PRE_DIV2_LAST;
    wire wrap_w = (pre_r >= last_w);

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pre_r <= '0;
        end else if (clear_i || wrap_w) begin
            pre_r <= '0;
        end else begin
            pre_r <= pre_r + 7'h01;
        end
    end

    assign tick_o = wrap_w && !clear_i;

endmodule : fsw_prescaler

// [rtl/fsw_watchdog.sv]
/*
 * Fail-safe watchdog: 16-bit counter, service reload, disable window,
 * internal reset and reset output pin.
 * Assumes instruction strobes and configuration come from the CPU on
 * clk_sys_i as one-cycle pulses; no synchronisation is applied to them.
 */
`timescale 1ns/1ps
module fsw_watchdog (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // CPU side
    input wire fsw_pkg::fsw_instr_t instr_i,
    input wire fsw_pkg::fsw_cfg_t cfg_i,
    // Status and reset outputs
    output logic [15:0] count_o,
    output logic enabled_o,
    output logic init_done_o,
    output logic int_reset_o,
    output logic reset_output_pin_n_o
);

    ////////////////////////////////////////////////////////////////////////
    fsw_pkg::fsw_state_t state_r;
    fsw_pkg::fsw_state_t state_nxt;
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic en_r;
    logic eoi_r;
    logic div128_r;
    logic [7:0] reload_r;
    logic [3:0] pulse_r;
    logic rst_pin_r;
    logic irst_r;
    logic tick_w;
    logic [24:0] gap_r;
    logic cfg_moved_r;

    wire in_reset_w = (state_r == fsw_pkg::ST_RESET);
    wire service_w = instr_i.service_watchdog_instr && !in_reset_w;
    wire disable_w = instr_i.disable_watchdog_instr && !eoi_r && !in_reset_w;
    wire eoi_w = instr_i.end_of_init_instr && !in_reset_w;
    wire overflow_w = en_r && tick_w && (cnt_r == 16'hffff);
    wire pulse_done_w = (pulse_r == fsw_pkg::RST_PULSE_LAST);

    fsw_prescaler u_pre (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .clear_i(service_w || in_reset_w),
        .div128_i(div128_r),
        .tick_o(tick_w)
    );

    // Service takes priority over a tick so the interval restarts cleanly
    always_comb begin
        cnt_nxt = cnt_r;
        if (in_reset_w) begin
            cnt_nxt = fsw_pkg::CNT_RESET;
        end else if (service_w) begin
            cnt_nxt = {reload_r, 8'h00};
        end else if (en_r && tick_w) begin
            cnt_nxt = cnt_r + 16'h0001;
        end
    end

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            fsw_pkg::ST_INIT: begin
                if (overflow_w) state_nxt = fsw_pkg::ST_RESET;
                else if (eoi_w) state_nxt = fsw_pkg::ST_RUN;
            end
            fsw_pkg::ST_RUN: begin
                if (overflow_w) state_nxt = fsw_pkg::ST_RESET;
            end
            fsw_pkg::ST_RESET: begin
                if (pulse_done_w) state_nxt = fsw_pkg::ST_INIT;
            end
            default: state_nxt = fsw_pkg::ST_INIT;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= fsw_pkg::ST_INIT;
            cnt_r <= fsw_pkg::CNT_RESET;
            pulse_r <= 4'h0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            pulse_r <= in_reset_w ? pulse_r + 4'h1 : 4'h0;
        end
    end

    // Watchdog reset re-runs the whole start-up, like a chip reset
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            en_r <= 1'b1;
            eoi_r <= 1'b0;
        end else if (in_reset_w) begin
            en_r <= 1'b1;
            eoi_r <= 1'b0;
        end else begin
            if (disable_w) en_r <= 1'b0;
            if (eoi_w) eoi_r <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            div128_r <= fsw_pkg::PRESEL_RESET;
            reload_r <= fsw_pkg::RELOAD_RESET;
        end else if (in_reset_w) begin
            div128_r <= fsw_pkg::PRESEL_RESET;
            reload_r <= fsw_pkg::RELOAD_RESET;
        end else if (cfg_i.wr) begin
            div128_r <= cfg_i.presel_div128;
            reload_r <= cfg_i.watchdog_reload_value;
        end
    end

    // Pin stays low through start-up and any watchdog reset
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_pin_r <= 1'b0;
            irst_r <= 1'b0;
        end else begin
            rst_pin_r <= (state_nxt == fsw_pkg::ST_RUN);
            irst_r <= (state_nxt == fsw_pkg::ST_RESET);
        end
    end

    assign count_o = cnt_r;
    assign enabled_o = en_r;
    assign init_done_o = eoi_r;
    assign int_reset_o = irst_r;
    assign reset_output_pin_n_o = rst_pin_r;

    ////////////////////////////////////////////////////////////////////////
    // Assertion helpers: clocks since the interval started, and whether the
    // configuration moved since then, which voids the interval length check
    wire [8:0] steps_w = 9'h100 - {1'b0, reload_r};
    wire [7:0] ratio_w = div128_r ? ({1'b0, fsw_pkg::PRE_DIV128_LAST} + 8'h01)
                                  : ({1'b0, fsw_pkg::PRE_DIV2_LAST} + 8'h01);
    wire [24:0] span_w = 25'({steps_w, 8'h00}) * 25'(ratio_w);

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            gap_r <= 25'h0000000;
            cfg_moved_r <= 1'b0;
        end else if (in_reset_w) begin
            gap_r <= 25'h0000000;
            cfg_moved_r <= 1'b0;
        end else begin
            gap_r <= service_w ? 25'h0000000 : gap_r + 25'h0000001;
            if (cfg_i.wr) begin
                cfg_moved_r <= 1'b1;
            end else if (service_w) begin
                cfg_moved_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_ovf;
        overflow_w;
    endsequence

    a_ovf_reset: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        s_ovf |=> int_reset_o && !reset_output_pin_n_o)
        else $error("overflow did not raise reset");
    a_reset_len: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        $rose(int_reset_o) |-> int_reset_o [*8] ##1 !int_reset_o)
        else $error("internal reset pulse length wrong");
    a_service_load: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        service_w |=> count_o == {$past(reload_r), 8'h00})
        else $error("service did not reload counter");
    a_disable_late: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        init_done_o && enabled_o && !in_reset_w |=> enabled_o)
        else $error("watchdog disabled after end of init");
    a_disable_early: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        instr_i.disable_watchdog_instr && !init_done_o && !in_reset_w |=> !enabled_o)
        else $error("disable before end of init ignored");
    a_eoi_pin: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        eoi_w && !overflow_w |=> reset_output_pin_n_o && init_done_o)
        else $error("end of init did not release pin");
    a_div2_rate: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        !div128_r && en_r && !service_w && !in_reset_w && tick_w |=> !tick_w)
        else $error("divide-by-2 tick too fast");
    a_count_hold: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        !enabled_o && !service_w && !in_reset_w |=> $stable(count_o))
        else $error("disabled counter moved");
    a_restart_en: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        $fell(int_reset_o) |-> enabled_o && !init_done_o && count_o == 16'h0000)
        else $error("start-up state wrong after watchdog reset");

    sequence s_rst_pulse;
        int_reset_o [*8];
    endsequence

    sequence s_rst_exit;
        !int_reset_o && !reset_output_pin_n_o && enabled_o;
    endsequence

    a_ovf_cycle: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        s_ovf |=> s_rst_pulse ##1 s_rst_exit)
        else $error("overflow reset sequence wrong");
    a_ovf_interval: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        s_ovf and !cfg_moved_r |-> gap_r == span_w - 25'h0000001)
        else $error("supervised interval length wrong");
    a_pin_held: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        !init_done_o |-> !reset_output_pin_n_o)
        else $error("reset pin released before end of init");
    a_pin_release: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        init_done_o && !int_reset_o |-> reset_output_pin_n_o)
        else $error("reset pin low after end of init");
    a_reset_clear: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        int_reset_o |=> count_o == fsw_pkg::CNT_RESET)
        else $error("counter not cleared in watchdog reset");
    a_cfg_default: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        int_reset_o |=> div128_r == fsw_pkg::PRESEL_RESET && reload_r == fsw_pkg::RELOAD_RESET)
        else $error("configuration not restored in watchdog reset");
    a_low_byte: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        service_w |=> count_o[7:0] == 8'h00)
        else $error("service did not clear low byte");

endmodule : fsw_watchdog

// [testbench/fsw_ext_part.sv]
/*
 * Far-side part that is reset through the reset output pin.
 * Assumes the pin is sampled on the system clock.
 */
`timescale 1ns/1ps
module fsw_ext_part (
    // Clock and pin
    input wire logic clk_sys_i,
    input wire logic reset_output_pin_n_i,
    // Resets seen after a release
    output int resets_o
);
    logic seen_high_r = 1'b0;
    initial resets_o = 0;
    // Counts only falls after a release, so the start-up low is not a reset
    always @(posedge clk_sys_i) begin
        if (reset_output_pin_n_i === 1'b1) begin
            seen_high_r <= 1'b1;
        end else if (seen_high_r && reset_output_pin_n_i === 1'b0) begin
            seen_high_r <= 1'b0;
            resets_o <= resets_o + 1;
        end
    end
endmodule : fsw_ext_part

// [testbench/tb.sv]
/*
 * Self-checking bench for the watchdog.
 * Assumes strobes are one-cycle pulses and outputs answer one cycle later.
 */
`timescale 1ns/1ps
module tb;
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    fsw_pkg::fsw_instr_t instr = '0;
    fsw_pkg::fsw_cfg_t cfg = '0;
    logic [15:0] count_o;
    logic enabled_o, init_done_o, int_reset_o, reset_output_pin_n_o;
    int resets, fail_count = 0, compares = 0, cyc = 0, n, m;
    logic [7:0] rel;
    logic [15:0] base;
    int m_cnt = 0, m_pre = 0, m_en = 1, m_eoi = 0, m_div = 0, m_rel = 0, m_rst = 0;
    int m_pin = 0, m_svc, m_wrap, m_tick, m_ovf;
    int m_ovf_q[$];

    fsw_watchdog dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .instr_i(instr),
        .cfg_i(cfg), .count_o(count_o), .enabled_o(enabled_o), .init_done_o(init_done_o),
        .int_reset_o(int_reset_o), .reset_output_pin_n_o(reset_output_pin_n_o));
    fsw_ext_part ext (.clk_sys_i(clk_sys_i), .reset_output_pin_n_i(reset_output_pin_n_o),
        .resets_o(resets));

    initial begin
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("compares %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    // A hang counts as a mismatch
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            fail_count++;
            test_done();
        end
    end

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Reference model from the rules; the queue logs each modelled overflow
    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i || m_rst > 0) begin
            m_rst = reset_n_i ? m_rst - 1 : 0;
            m_cnt = 0;
            m_pre = 0;
            m_en = 1;
            m_eoi = 0;
            m_div = 0;
            m_rel = 0;
            m_pin = 0;
        end else begin
            m_svc = instr.service_watchdog_instr;
            m_wrap = m_pre >= (m_div ? 128 : 2) - 1;
            m_tick = m_wrap && !m_svc;
            m_ovf = m_en && m_tick && m_cnt == 65535;
            m_pre = (m_svc || m_wrap) ? 0 : m_pre + 1;
            if (m_svc) begin
                m_cnt = m_rel * 256;
            end else if (m_en && m_tick) begin
                m_cnt = (m_cnt + 1) % 65536;
            end
            if (instr.disable_watchdog_instr && !m_eoi) begin
                m_en = 0;
            end
            if (instr.end_of_init_instr) begin
                m_eoi = 1;
            end
            if (cfg.wr) begin
                m_div = cfg.presel_div128;
                m_rel = cfg.watchdog_reload_value;
            end
            if (m_ovf) begin
                m_rst = fsw_pkg::RST_PULSE_CYC;
                m_pin = 0;
                m_ovf_q.push_back(cyc);
            end else if (instr.end_of_init_instr) begin
                m_pin = 1;
            end
        end
    end

    // Outputs are settled at the falling edge
    always @(negedge clk_sys_i) begin
        chk("model count", 16'(m_cnt), count_o);
        chk("model enabled", 16'(m_en), 16'(enabled_o));
        chk("model init done", 16'(m_eoi), 16'(init_done_o));
        chk("model int reset", 16'(m_rst > 0), 16'(int_reset_o));
        chk("model pin", 16'(m_pin), 16'(reset_output_pin_n_o));
    end

    task automatic step(input int k);
        repeat (k) @(posedge clk_sys_i);
        #1;
    endtask : step

    task automatic pulse(input logic [2:0] s);
        instr = s;
        step(1);
        instr = '0;
    endtask : pulse

    task automatic wcfg(input logic d, input logic [7:0] r);
        cfg = {1'b1, d, r};
        step(1);
        cfg.wr = 1'b0;
    endtask : wcfg

    task automatic do_reset();
        reset_n_i = 1'b0;
        step(5);
        reset_n_i = 1'b1;
    endtask : do_reset

    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h4fc6));
        do_reset();
        chk("count", 16'h0000, count_o);
        chk("enabled", 1, enabled_o);
        chk("pin", 0, reset_output_pin_n_o);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            rel = 8'($urandom_range(254, 0));
            wcfg(i[1], rel);
            pulse(3'b100);
            base = {rel, 8'h00};
            chk("reload", base, count_o);
            step(i[1] ? 1280 : 20);
            chk("ticks", base + 16'd10, count_o);
        end
        $display("test prescaler done");
        pulse(3'b010);
        base = count_o;
        chk("enabled", 0, enabled_o);
        step(300);
        chk("stopped", base, count_o);
        do_reset();
        chk("enabled", 1, enabled_o);
        pulse(3'b001);
        chk("pin", 1, reset_output_pin_n_o);
        step(1);
        pulse(3'b010);
        chk("enabled", 1, enabled_o);
        $display("test disable done");
        wcfg(1'b0, 8'hff);
        pulse(3'b100);
        n = 0;
        while (int_reset_o !== 1'b1 && n < 600) begin
            step(1);
            n++;
        end
        chk("ovf time", 1, n inside {511, 512});
        chk("pin", 0, reset_output_pin_n_o);
        m = 0;
        while (int_reset_o === 1'b1 && m < 20) begin
            step(1);
            m++;
        end
        chk("pulse", fsw_pkg::RST_PULSE_CYC, m);
        chk("ext", 1, resets);
        chk("ext model", m_ovf_q.size(), resets);
        chk("init", 0, init_done_o);
        pulse(3'b100);
        chk("reload", 16'h0000, count_o);
        $display("test overflow done");
        test_done();
    end
endmodule : tb
